// File: src/pifb_consts.vh
// register offsets, field positions and reset values of the flag bank
`ifndef PIFB_CONSTS_VH
`define PIFB_CONSTS_VH
`define PIFB_ADDR_EDGE 4'h0
`define PIFB_ADDR_PIN 4'h1
`define PIFB_ADDR_PFL1 4'h2
`define PIFB_ADDR_PFL2 4'h3
`define PIFB_ADDR_PEN2 4'h4
`define PIFB_ADDR_CTRL 4'h5
`define PIFB_ADDR_EN1 4'h6
`define PIFB_ADDR_PRI 4'h7
`define PIFB_ADDR_LEVEL 4'h8
`define PIFB_EDGE_MASK 8'hf5
`define PIFB_EDGE_RESET 8'hf5
`define PIFB_PIN_MASK 8'hdb
`define PIFB_PIN_RESET 8'hc0
`define PIFB_PFL1_MASK 8'hfb
`define PIFB_PFL2_MASK 8'h1e
`define PIFB_CTRL_RESET 8'h80
`define PIFB_PRI_RESET 16'h1efb
`define PIFB_HIGH_VECTOR 24'h000008
`define PIFB_LOW_VECTOR 24'h000018
`endif

// File: src/pifb_edge_detect.v
// synchronised edge detector for one external pin
`timescale 1ns/1ps
module pifb_edge_detect (
    // clock and reset
    input wire sys_clk,
    input wire rst_b,
    // pin and polarity
    input wire pinIn,
    input wire riseSel,
    output wire edgeHit
);
    reg sync1_r;
    reg sync2_r;
    reg last_r;
    // chain fill marker: a pin idling high must not look like an edge
    reg [2:0] fill_r;
    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            last_r <= 1'b0;
            fill_r <= 3'h0;
        end
        else
        begin
            fill_r <= {fill_r[1:0], 1'b1};
            sync1_r <= pinIn;
            sync2_r <= sync1_r;
            last_r <= sync2_r;
        end
    end
    // one pulse per qualifying edge
    assign edgeHit = fill_r[2] &
        (riseSel ? (sync2_r & ~last_r) : (~sync2_r & last_r));
endmodule

// File: src/pifb_flag_bank.v
// interrupt flag, enable and priority bank with avalon-mm register slave
// How it works
// - edge-select bit picks rising (1) or falling (0) edge per pin
// - edge control bit 7 set kills every port pull-up, else latch
// - flags set on their event whatever the enables say
// - timer0 and port change priority bits: 1 high, 0 low
// - pin-2 and pin-1 priority: 1 high, reset to 1
// - pin-2 and pin-1 enables: 1 permits, reset to 0
// - pin flags set by selected edge, held till software writes 0
// - unimplemented bit positions read zero; enable-1, priority and control regs keep all written bits
// - parallel port flag set on external access, held till cleared
// - converter flag set at conversion end, held till cleared
// - receive flag read-only, mirrors full buffer, cleared by reading it
// - transmit flag read-only, high while buffer empty, write clears
// - sync serial flag set on transfer end, held till cleared
// - timer2 match and timer1 overflow flags, software clear only
// - memory write flag set on write completion, software clears
// - collision and low-voltage flags set on event, held till cleared
// - timer3 flag sticky; second-bank enables permit when 1
// - priority bits matter only while priority mode is on
// - flag, enable and global enable together vector at once by level
// - priority mode enabled by bit 7 of the reset control register
// - high-level request may preempt a running low-level handler
//
// Design decisions made here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`include "pifb_consts.vh"
module pifb_flag_bank #(
    parameter NPIN = 3
) (
    // clock and reset
    input wire sys_clk,
    input wire rst_b,
    // avalon-mm slave
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    // external interrupt pins (0, 1, 2)
    input wire [NPIN-1:0] extPin,
    // port b pull-ups
    input wire [7:0] portbLatch,
    output wire [7:0] portbPullupOn,
    // peripheral events, one-cycle pulses; serial buffer full/empty are levels
    input wire parallelPortEvt,
    input wire converterDoneEvt,
    input wire serialRxFull,
    input wire serialTxEmpty,
    input wire syncSerialEvt,
    input wire timer2MatchEvt,
    input wire timer1OvfEvt,
    input wire memWriteDoneEvt,
    input wire collisionEvt,
    input wire lowVoltageEvt,
    input wire timer3OvfEvt,
    // core side
    input wire vectorAck,
    input wire handlerReturn,
    output reg highRequest,
    output reg lowRequest,
    output reg [23:0] vectorAddr,
    output wire [NPIN-1:0] extEdgeSeen
);
    localparam LVL_IDLE = 2'h0;
    localparam LVL_LOW = 2'h1;
    localparam LVL_HIGH = 2'h2;

    reg [7:0] edgeCtl_r;
    reg [7:0] pinCtl_r;
    reg [7:0] pen2_r;
    reg [7:0] resetCtl_r;
    reg [7:0] en1_r;
    reg [15:0] pri_r;
    reg [1:0] level_r;
    reg [1:0] level_nxt;
    reg [1:0] savedLevel_r;
    reg ack_r;
    wire [NPIN-1:0] edgeSel;
    wire [10:0] setVec;
    wire [10:0] clrVec;
    wire [10:0] flagVec;
    wire [7:0] pfl1Read;
    wire [7:0] pfl2Read;
    wire [7:0] pinRead;
    wire acc;
    wire wrEn;
    wire [7:0] wd;
    wire priorityMode;
    wire globalHigh;
    wire globalLow;

    // a single-cycle wait gives registered read data
    assign acc = (avs_read | avs_write) & ~ack_r;
    assign avs_waitrequest = acc;
    assign wrEn = avs_write & ack_r;
    assign wd = avs_writedata[7:0];

    function wrHit;
        input [3:0] a;
        input [3:0] target;
        input w;
        begin
            wrHit = w & (a == target);
        end
    endfunction

    // edge select bits 6..4 map to pins 0..2
    assign edgeSel[0] = edgeCtl_r[6];
    assign edgeSel[1] = edgeCtl_r[5];
    assign edgeSel[2] = edgeCtl_r[4];

    genvar g;
    generate
        for (g = 0; g < NPIN; g = g + 1)
        begin : gPin
            pifb_edge_detect uEdge (
                .sys_clk(sys_clk),
                .rst_b(rst_b),
                .pinIn(extPin[g]),
                .riseSel(edgeSel[g]),
                .edgeHit(extEdgeSeen[g])
            );
        end
    endgenerate

    // flag order: ext1 ext2 par conv ssp t2 t1 mem col lv t3
    assign setVec = {timer3OvfEvt, lowVoltageEvt, collisionEvt,
        memWriteDoneEvt, timer1OvfEvt, timer2MatchEvt, syncSerialEvt,
        converterDoneEvt, parallelPortEvt, extEdgeSeen[2],
        extEdgeSeen[1]};
    assign clrVec = {
        wrHit(avs_address, `PIFB_ADDR_PFL2, wrEn) & ~wd[1],
        wrHit(avs_address, `PIFB_ADDR_PFL2, wrEn) & ~wd[2],
        wrHit(avs_address, `PIFB_ADDR_PFL2, wrEn) & ~wd[3],
        wrHit(avs_address, `PIFB_ADDR_PFL2, wrEn) & ~wd[4],
        wrHit(avs_address, `PIFB_ADDR_PFL1, wrEn) & ~wd[0],
        wrHit(avs_address, `PIFB_ADDR_PFL1, wrEn) & ~wd[1],
        wrHit(avs_address, `PIFB_ADDR_PFL1, wrEn) & ~wd[3],
        wrHit(avs_address, `PIFB_ADDR_PFL1, wrEn) & ~wd[6],
        wrHit(avs_address, `PIFB_ADDR_PFL1, wrEn) & ~wd[7],
        wrHit(avs_address, `PIFB_ADDR_PIN, wrEn) & ~wd[1],
        wrHit(avs_address, `PIFB_ADDR_PIN, wrEn) & ~wd[0]};

    generate
        for (g = 0; g < 11; g = g + 1)
        begin : gFlag
            pifb_flag_cell uFlag (
                .sys_clk(sys_clk),
                .rst_b(rst_b),
                .setEvt(setVec[g]),
                .clrReq(clrVec[g]),
                .flag_r(flagVec[g])
            );
        end
    endgenerate

    // receive and transmit flags track their buffers directly
    assign pfl1Read = {flagVec[2], flagVec[3], serialRxFull,
        serialTxEmpty, flagVec[4], 1'b0, flagVec[5],
        flagVec[6]};
    assign pfl2Read = {3'h0, flagVec[7], flagVec[8], flagVec[9],
        flagVec[10], 1'b0};
    assign pinRead = {pinCtl_r[7:6], 1'b0, pinCtl_r[4:3], 1'b0,
        flagVec[1], flagVec[0]};

    assign portbPullupOn = edgeCtl_r[7] ? 8'h00 : portbLatch;

    // control registers
    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            edgeCtl_r <= `PIFB_EDGE_RESET;
            pinCtl_r <= `PIFB_PIN_RESET;
            pen2_r <= 8'h00;
            resetCtl_r <= `PIFB_CTRL_RESET;
            en1_r <= 8'h00;
            pri_r <= `PIFB_PRI_RESET;
            ack_r <= 1'b0;
        end
        else
        begin
            ack_r <= acc;
            if (wrHit(avs_address, `PIFB_ADDR_EDGE, wrEn))
                edgeCtl_r <= wd & `PIFB_EDGE_MASK;
            if (wrHit(avs_address, `PIFB_ADDR_PIN, wrEn))
                pinCtl_r <= wd & 8'hd8;
            if (wrHit(avs_address, `PIFB_ADDR_PEN2, wrEn))
                pen2_r <= wd & `PIFB_PFL2_MASK;
            if (wrHit(avs_address, `PIFB_ADDR_CTRL, wrEn))
                resetCtl_r <= wd;
            if (wrHit(avs_address, `PIFB_ADDR_EN1, wrEn))
                en1_r <= wd;
            if (wrHit(avs_address, `PIFB_ADDR_PRI, wrEn))
                pri_r <= avs_writedata[15:0];
        end
    end

    // registered read data, unmapped reads return zero
    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            avs_readdata <= 32'h0;
        else if (avs_read & ~ack_r)
        begin
            case (avs_address)
                `PIFB_ADDR_EDGE: avs_readdata <= {24'h0, edgeCtl_r};
                `PIFB_ADDR_PIN: avs_readdata <= {24'h0, pinRead};
                `PIFB_ADDR_PFL1: avs_readdata <= {24'h0, pfl1Read};
                `PIFB_ADDR_PFL2: avs_readdata <= {24'h0, pfl2Read};
                `PIFB_ADDR_PEN2: avs_readdata <= {24'h0, pen2_r};
                `PIFB_ADDR_CTRL: avs_readdata <= {24'h0, resetCtl_r};
                `PIFB_ADDR_EN1: avs_readdata <= {24'h0, en1_r};
                `PIFB_ADDR_PRI: avs_readdata <= {16'h0, pri_r};
                `PIFB_ADDR_LEVEL: avs_readdata <= {30'h0, level_r};
                default: avs_readdata <= 32'h0;
            endcase
        end
    end

    // control byte: bit7 priority mode, bit6 high global, bit5 low global
    assign priorityMode = resetCtl_r[7];
    assign globalHigh = resetCtl_r[6];
    assign globalLow = resetCtl_r[5];

    // request sources: pin1, pin2, pfl1 bits, pfl2 bits
    wire [12:0] srcFlag;
    wire [12:0] srcEn;
    wire [12:0] srcPri;
    wire [12:0] active;
    wire [12:0] isHigh;
    assign srcFlag = {pfl2Read[4:1], pfl1Read[7:3], pfl1Read[1:0],
        flagVec[1], flagVec[0]};
    assign srcEn = {pen2_r[4:1], en1_r[7:3], en1_r[1:0],
        pinCtl_r[4], pinCtl_r[3]};
    // pri_r: low byte first-bank priority, high byte second bank
    assign srcPri = {pri_r[12:9], pri_r[7:3], pri_r[1:0],
        pinCtl_r[7], pinCtl_r[6]};
    assign active = srcFlag & srcEn;
    // without priority mode every source counts as high level
    assign isHigh = priorityMode ? srcPri : 13'h1fff;

    // timer0 and port-change priorities are exported on the edge reg only
    always @*
    begin
        highRequest = globalHigh & |(active & isHigh);
        lowRequest = priorityMode & globalLow & |(active & ~isHigh);
        level_nxt = level_r;
        case (level_r)
            LVL_IDLE:
            begin
                if (vectorAck & highRequest)
                    level_nxt = LVL_HIGH;
                else if (vectorAck & lowRequest)
                    level_nxt = LVL_LOW;
            end
            LVL_LOW:
            begin
                lowRequest = 1'b0;
                if (vectorAck & highRequest)
                    level_nxt = LVL_HIGH;
                else if (handlerReturn)
                    level_nxt = LVL_IDLE;
            end
            LVL_HIGH:
            begin
                highRequest = 1'b0;
                lowRequest = 1'b0;
                if (handlerReturn)
                    level_nxt = savedLevel_r;
            end
            default: level_nxt = LVL_IDLE;
        endcase
    end

    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            level_r <= LVL_IDLE;
            savedLevel_r <= LVL_IDLE;
            vectorAddr <= 24'h0;
        end
        else
        begin
            level_r <= level_nxt;
            if (level_r != LVL_HIGH && level_nxt == LVL_HIGH)
            begin
                savedLevel_r <= level_r;
                vectorAddr <= `PIFB_HIGH_VECTOR;
            end
            else if (level_r == LVL_IDLE && level_nxt == LVL_LOW)
                vectorAddr <= `PIFB_LOW_VECTOR;
        end
    end
endmodule

// File: src/pifb_flag_cell.v
// sticky flag with software clear; set beats clear
`timescale 1ns/1ps
module pifb_flag_cell (
    // clock and reset
    input wire sys_clk,
    input wire rst_b,
    // set and clear
    input wire setEvt,
    input wire clrReq,
    output reg flag_r
);
    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            flag_r <= 1'b0;
        else if (setEvt)
            flag_r <= 1'b1;
        else if (clrReq)
            flag_r <= 1'b0;
    end
endmodule

// File: tb/pifb_flag_bank_chk.sv
// port-level assertions for the flag bank
`timescale 1ns/1ps
`include "pifb_consts.vh"
module pifb_flag_bank_chk #(
    parameter NPIN = 3
) (
    // clock and reset
    input wire sys_clk,
    input wire rst_b,
    // register bus
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    // pins and core
    input wire [7:0] portbLatch,
    input wire [7:0] portbPullupOn,
    input wire serialRxFull,
    input wire serialTxEmpty,
    input wire vectorAck,
    input wire highRequest,
    input wire lowRequest,
    input wire [23:0] vectorAddr,
    input wire [NPIN-1:0] extEdgeSeen
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    reg [7:0] edgeSh_r;
    reg [7:0] ctrlSh_r;
    reg [31:0] impl;
    wire rdDone = avs_read && !avs_waitrequest;
    // shadows follow only writes the slave really took
    always @(posedge sys_clk or negedge rst_b)
        if (!rst_b)
        begin
            edgeSh_r <= `PIFB_EDGE_RESET;
            ctrlSh_r <= `PIFB_CTRL_RESET;
        end
        else if (avs_write && !avs_waitrequest)
        begin
            if (avs_address == `PIFB_ADDR_EDGE)
                edgeSh_r <= avs_writedata[7:0];
            if (avs_address == `PIFB_ADDR_CTRL)
                ctrlSh_r <= avs_writedata[7:0];
        end
    always @*
        case (avs_address)
            4'h0: impl = 32'hf5;
            4'h1: impl = 32'hdb;
            4'h2: impl = 32'hfb;
            4'h3, 4'h4: impl = 32'h1e;
            4'h5, 4'h6, 4'h7, 4'h8: impl = 32'hffffffff;
            default: impl = 32'h0;
        endcase
    AST_PULLUP: assert property (portbPullupOn == (edgeSh_r[7] ? 8'h0 : portbLatch))
        else $error("pull-up enables wrong");
    AST_WAIT_ONE: assert property (avs_waitrequest |=> !avs_waitrequest)
        else $error("wait longer than one cycle");
    AST_UNUSED_ZERO: assert property (rdDone |-> (avs_readdata & ~impl) == 32'h0)
        else $error("unimplemented bit read as one");
    AST_RX_TX: assert property (rdDone && avs_address == 4'h2 && $stable(serialRxFull)
        && $stable(serialTxEmpty) |-> avs_readdata[5:4] == {serialRxFull, serialTxEmpty})
        else $error("serial flags do not mirror buffers");
    AST_EDGE_ONCE: assert property (extEdgeSeen != 0 |=> extEdgeSeen == 0)
        else $error("one pin edge seen twice");
    AST_VEC_HIGH: assert property (vectorAck && highRequest |=> vectorAddr == 24'h8)
        else $error("high vector wrong");
    AST_VEC_LOW: assert property (vectorAck && lowRequest && !highRequest
        |=> vectorAddr == 24'h18)
        else $error("low vector wrong");
    AST_NO_LOW: assert property (!ctrlSh_r[7] || !ctrlSh_r[5] |-> !lowRequest)
        else $error("low request without its enables");
    AST_NO_HIGH: assert property (!ctrlSh_r[6] |-> !highRequest)
        else $error("high request without global enable");
    cover property (rdDone);
    cover property (vectorAck && lowRequest);
    cover property (vectorAck && highRequest);
endmodule
bind pifb_flag_bank pifb_flag_bank_chk #(.NPIN(NPIN)) u_chk (.*);

// File: tb/pifb_peer.sv
// behavioural core and peripheral event sources facing the flag bank
`timescale 1ns/1ps
module pifb_peer #(
    parameter DLY = 2
) (
    // clock and reset
    input wire sys_clk,
    input wire rst_b,
    // bench commands
    input wire [8:0] fire,
    input wire retGo,
    // core side
    input wire highRequest,
    input wire lowRequest,
    output reg [8:0] evtPulse,
    output reg vectorAck,
    output reg handlerReturn
);
    reg [1:0] lvl_r;
    reg [3:0] wait_r;
    // a low handler may be preempted, a high one never
    wire want = (highRequest && lvl_r != 2'h2) || (lowRequest && lvl_r == 2'h0);
    always @(posedge sys_clk or negedge rst_b)
        if (!rst_b)
        begin
            evtPulse <= 9'h0;
            vectorAck <= 1'b0;
            handlerReturn <= 1'b0;
            lvl_r <= 2'h0;
            wait_r <= 4'h0;
        end
        else
        begin
            evtPulse <= fire;
            handlerReturn <= retGo;
            vectorAck <= (wait_r == DLY);
            wait_r <= 4'h0;
            if (wait_r == DLY)
                lvl_r <= highRequest ? 2'h2 : 2'h1;
            else if (retGo)
                lvl_r <= 2'h0;
            else if (want)
                wait_r <= wait_r + 4'h1;
        end
endmodule

// File: tb/prioritized_interrupt_flag_bank_bench.sv
// self-checking bench for the flag bank
`timescale 1ns/1ps
module prioritized_interrupt_flag_bank_bench;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [2:0] extPin = 3'h0;
    logic [7:0] portbLatch = 8'ha5;
    logic serialRxFull = 1'b0;
    logic serialTxEmpty = 1'b1;
    logic [8:0] fire = 9'h0;
    logic retGo = 1'b0;
    wire [31:0] avs_readdata;
    wire avs_waitrequest, highRequest, lowRequest, vectorAck, handlerReturn;
    wire [7:0] portbPullupOn;
    wire [23:0] vectorAddr;
    wire [8:0] ev;
    int mismatches = 0;
    int n_compared = 0;
    logic [31:0] rdat, base;
    logic [3:0] fa;
    int bitPos [0:8] = '{7, 6, 3, 1, 0, 4, 3, 2, 1};
    always #5 sys_clk = ~sys_clk;
    pifb_flag_bank #(.NPIN(3)) u_dut (.sys_clk(sys_clk), .rst_b(rst_b),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .extPin(extPin),
        .portbLatch(portbLatch), .portbPullupOn(portbPullupOn),
        .parallelPortEvt(ev[0]), .converterDoneEvt(ev[1]),
        .serialRxFull(serialRxFull), .serialTxEmpty(serialTxEmpty),
        .syncSerialEvt(ev[2]), .timer2MatchEvt(ev[3]), .timer1OvfEvt(ev[4]),
        .memWriteDoneEvt(ev[5]), .collisionEvt(ev[6]), .lowVoltageEvt(ev[7]),
        .timer3OvfEvt(ev[8]), .vectorAck(vectorAck),
        .handlerReturn(handlerReturn), .highRequest(highRequest),
        .lowRequest(lowRequest), .vectorAddr(vectorAddr), .extEdgeSeen());
    pifb_peer #(.DLY(2)) u_peer (.sys_clk(sys_clk), .rst_b(rst_b),
        .fire(fire), .retGo(retGo), .highRequest(highRequest),
        .lowRequest(lowRequest), .evtPulse(ev), .vectorAck(vectorAck),
        .handlerReturn(handlerReturn));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // request held until the edge that samples waitrequest low
    task automatic access(input logic wr, input logic [3:0] a,
                          input logic [31:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge sys_clk);
        rdat = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
        access(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic pulse(input int k);
        @(posedge sys_clk);
        fire <= 9'h1 << k;
        @(posedge sys_clk);
        fire <= 9'h0;
        cyc(3);
    endtask
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        cyc(5000);
        mismatches++;
        end_of_test;
    end
    initial
    begin
        cyc(2);
        rst_b <= 1'b1;
        rdchk(4'h0, 32'hf5);
        rdchk(4'h1, 32'hc0);
        rdchk(4'h2, 32'h10);
        rdchk(4'h4, 32'h0);
        rdchk(4'h7, 32'h1efb);
        access(1'b1, 4'h9, 32'hff);
        rdchk(4'h9, 32'h0);
        access(1'b1, 4'h0, 32'hff);
        rdchk(4'h0, 32'hf5);
        chk({24'h0, portbPullupOn}, 32'h0);
        access(1'b1, 4'h1, 32'hff);
        rdchk(4'h1, 32'hd8);
        access(1'b1, 4'h1, 32'hc0);
        access(1'b1, 4'h0, 32'h70);
        cyc(1);
        chk({24'h0, portbPullupOn}, {24'h0, portbLatch});
        for (int i = 1; i < 3; i++)
        begin
            extPin[i] <= 1'b1;
            cyc(5);
            rdchk(4'h1, 32'hc0 | i);
            access(1'b1, 4'h1, 32'hc0);
            access(1'b1, 4'h0, 32'h0);
            extPin[i] <= 1'b0;
            cyc(5);
            rdchk(4'h1, 32'hc0 | i);
            access(1'b1, 4'h1, 32'hc0);
            extPin[i] <= 1'b1;
            cyc(5);
            rdchk(4'h1, 32'hc0);
            access(1'b1, 4'h0, 32'h70);
        end
        // enables stay zero: flags must still set
        for (int k = 0; k < 9; k++)
        begin
            fa = (k < 5) ? 4'h2 : 4'h3;
            base = (k < 5) ? 32'h10 : 32'h0;
            pulse(k);
            access(1'b1, fa, 32'hff);
            rdchk(fa, base | (32'h1 << bitPos[k]));
            access(1'b1, fa, 32'h0);
            rdchk(fa, base);
        end
        serialRxFull <= 1'b1;
        serialTxEmpty <= 1'b0;
        access(1'b1, 4'h2, 32'h0);
        rdchk(4'h2, 32'h20);
        serialRxFull <= 1'b0;
        serialTxEmpty <= 1'b1;
        access(1'b1, 4'h7, 32'h2);
        access(1'b1, 4'h6, 32'h2);
        access(1'b1, 4'h4, 32'h2);
        access(1'b1, 4'h5, 32'he0);
        pulse(8);
        cyc(4);
        chk({8'h0, vectorAddr}, 32'h18);
        rdchk(4'h8, 32'h1);
        pulse(3);
        cyc(4);
        chk({8'h0, vectorAddr}, 32'h8);
        rdchk(4'h8, 32'h2);
        access(1'b1, 4'h2, 32'h0);
        access(1'b1, 4'h3, 32'h0);
        repeat (2)
        begin
            retGo <= 1'b1;
            cyc(1);
            retGo <= 1'b0;
            cyc(2);
        end
        // priority mode off on purpose: one level only
        access(1'b1, 4'h5, 32'h40);
        pulse(8);
        cyc(4);
        chk({8'h0, vectorAddr}, 32'h8);
        rdchk(4'h8, 32'h2);
        end_of_test;
    end
endmodule
